// ---- logic/pib_pkg.sv ----
// Purpose: shared constants and types of the peripheral interrupt enable/flag bank
// Assumes: 32-bit Avalon-MM data, byte addresses, one aligned word per register
// Notes: registers are up to 8 bits wide (event registers 3) and sit in the low byte of each word
package pib_pkg;

	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [5:0] OFS_MAIN_CTRL = 6'h00;
	localparam logic [5:0] OFS_ENABLE_ONE = 6'h04;
	localparam logic [5:0] OFS_REQUEST_ONE = 6'h14;
	localparam logic [5:0] OFS_EVT_STATUS = 6'h24;
	localparam logic [5:0] OFS_EVT_CLEAR = 6'h28;
	localparam logic [5:0] OFS_EVT_ENABLE = 6'h2c;

	// main control field positions
	localparam int MC_GLOBAL_GATE = 7;
	localparam int MC_PERIPH_GATE = 6;
	localparam int MC_TIMER0_EN = 5;
	localparam int MC_EXT_PIN_EN = 4;
	localparam int MC_PIN_CHANGE_EN = 3;
	localparam int MC_TIMER0_PEND = 2;
	localparam int MC_EXT_PIN_PEND = 1;
	localparam int MC_PIN_CHANGE_PEND = 0;
	localparam logic [7:0] MC_WRITE_MASK = 8'hfe;

	// request one: read-only serial flags
	localparam int REQ1_RX = 5;
	localparam int REQ1_TX = 4;

	// request four fields
	localparam int REQ4_COLLISION = 1;
	localparam int REQ4_EVENT = 0;

	// implemented bits per enable/request register, index 0 is register one
	localparam logic [3:0][7:0] IMPL_MASK = {8'h03, 8'h3a, 8'hf9, 8'hff};
	localparam logic [3:0][7:0] REQ_WRITE_MASK = {8'h03, 8'h3a, 8'hf9, 8'hcf};

	// event status bits of the bus-side interrupt
	localparam int EVT_W = 3;
	localparam int EVT_CORE_RISE = 0;
	localparam int EVT_FLAG_SET = 1;
	localparam int EVT_BAD_ACCESS = 2;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// hardware set pulses, one vector per request register
	typedef struct packed {
		logic [3:0][7:0] req;
		logic timer0;
		logic ext_pin;
	} pib_set_t;

	// level inputs owned by other peripherals
	typedef struct packed {
		logic serial_rx_pending;
		logic serial_tx_pending;
		logic pin_change_pending;
	} pib_level_t;

	typedef struct packed {
		logic [7:0] main_ctrl;
		logic [3:0][7:0] enable;
		logic [3:0][7:0] request;
		logic [EVT_W-1:0] evt_status;
		logic [EVT_W-1:0] evt_enable;
		logic ack;
		logic [7:0] rdata;
		logic core_irq;
		logic bus_irq;
	} pib_state_t;

endpackage : pib_pkg

// ---- logic/pib_bank.sv ----
// Purpose: peripheral interrupt enable and request flag bank with core request
// Assumes: set pulses and levels come from logic on sys_clk; Avalon-MM slave
// Notes: each access takes two cycles; waitrequest is high in the first
//
// How it works
// - no peripheral request reaches the core unless the peripheral gate is set
// - flags set on their condition regardless of any enable or gate
// - unimplemented enable and request bits read zero and ignore writes
// - every enable and request bit clears to zero on reset
// - enable two: osc fail 7, comparators 6 and 5, nv write 4, collision 3, capcmp 0
// - enable four: serial two collision at 1, serial two event at 0
// - request one holds eight flags, timer one gate at 7 down to timer one overflow
// - request one receive and transmit flags are read-only to software
// - request two mirrors the layout of enable two
// - request three mirrors the layout of enable three
// - serial two collision flag set by hardware, cleared only by software write
// - serial two event flag sticky until software clears, zero while in progress
// - enable one lets its source request, zero blocks it
// - a flag of one means pending, zero means nothing pending
// - global gate zero blocks every interrupt, one passes enabled ones; here it gates core_irq_req only, bus_irq ignores it
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module pib_bank (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [pib_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [pib_pkg::DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [pib_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire pib_pkg::pib_set_t hw_set,
	input wire pib_pkg::pib_level_t hw_level,
	output logic core_irq_req,
	output logic bus_irq,
	output logic global_irq_gate,
	output logic periph_irq_gate
);

	pib_pkg::pib_state_t st;
	pib_pkg::pib_state_t next_st;
	logic wr_acc;
	logic bad_access;
	logic periph_any;
	logic core_any;
	logic [7:0] wbyte;
	logic lane0;

	function automatic logic [7:0] read_byte(
		input pib_pkg::pib_state_t s,
		input logic [5:0] a
	);
		logic [7:0] r;
		r = 8'h00;
		if (a == pib_pkg::OFS_MAIN_CTRL) begin
			r = s.main_ctrl;
		end
		for (int i = 0; i < 4; i++) begin
			if (a == pib_pkg::OFS_ENABLE_ONE + 6'(4 * i)) begin
				r = s.enable[i] & pib_pkg::IMPL_MASK[i];
			end
			if (a == pib_pkg::OFS_REQUEST_ONE + 6'(4 * i)) begin
				r = s.request[i] & pib_pkg::IMPL_MASK[i];
			end
		end
		if (a == pib_pkg::OFS_EVT_STATUS) begin
			r = 8'(s.evt_status);
		end
		if (a == pib_pkg::OFS_EVT_ENABLE) begin
			r = 8'(s.evt_enable);
		end
		return r;
	endfunction : read_byte

	function automatic logic mapped(input logic [5:0] a);
		logic m;
		m = (a[1:0] == 2'b00) && (a <= pib_pkg::OFS_EVT_ENABLE);
		return m;
	endfunction : mapped

	always_comb begin
		next_st = st;
		wr_acc = write && st.ack;
		wbyte = writedata[7:0];
		lane0 = byteenable[0];
		bad_access = 1'b0;
		periph_any = 1'b0;
		core_any = 1'b0;

		// one wait cycle, answer on the second
		next_st.ack = (read || write) && !st.ack;
		if ((read || write) && !st.ack) begin
			next_st.rdata = read_byte(st, address);
		end
		if ((read || write) && st.ack) begin
			bad_access = !mapped(address)
				|| (write && (address == pib_pkg::OFS_EVT_STATUS));
		end

		// main control writable except the pin-change flag
		if (wr_acc && lane0 && address == pib_pkg::OFS_MAIN_CTRL) begin
			next_st.main_ctrl = (wbyte & pib_pkg::MC_WRITE_MASK)
				| (st.main_ctrl & ~pib_pkg::MC_WRITE_MASK);
		end
		// hardware set after the write so a set wins over a clear
		next_st.main_ctrl[pib_pkg::MC_TIMER0_PEND] =
			next_st.main_ctrl[pib_pkg::MC_TIMER0_PEND] | hw_set.timer0;
		next_st.main_ctrl[pib_pkg::MC_EXT_PIN_PEND] =
			next_st.main_ctrl[pib_pkg::MC_EXT_PIN_PEND] | hw_set.ext_pin;
		next_st.main_ctrl[pib_pkg::MC_PIN_CHANGE_PEND] = hw_level.pin_change_pending;

		for (int i = 0; i < 4; i++) begin
			// enable layouts fixed by the implemented mask
			if (wr_acc && lane0 && address == pib_pkg::OFS_ENABLE_ONE + 6'(4 * i)) begin
				next_st.enable[i] = wbyte & pib_pkg::IMPL_MASK[i];
			end
			// request layouts, software may write or clear
			if (wr_acc && lane0 && address == pib_pkg::OFS_REQUEST_ONE + 6'(4 * i)) begin
				next_st.request[i] = (wbyte & pib_pkg::REQ_WRITE_MASK[i])
					| (st.request[i] & ~pib_pkg::REQ_WRITE_MASK[i]);
			end
			// hardware set is sticky and beats a same-cycle clear
			next_st.request[i] = (next_st.request[i] | hw_set.req[i])
				& pib_pkg::IMPL_MASK[i];
		end
		// serial flags follow the serial unit, software cannot touch them
		next_st.request[0][pib_pkg::REQ1_RX] = hw_level.serial_rx_pending;
		next_st.request[0][pib_pkg::REQ1_TX] = hw_level.serial_tx_pending;

		// a source counts only when flag and enable are both one
		for (int i = 0; i < 4; i++) begin
			periph_any = periph_any | (|(next_st.enable[i] & next_st.request[i]));
		end
		core_any = (next_st.main_ctrl[pib_pkg::MC_TIMER0_EN]
				&& next_st.main_ctrl[pib_pkg::MC_TIMER0_PEND])
			|| (next_st.main_ctrl[pib_pkg::MC_EXT_PIN_EN]
				&& next_st.main_ctrl[pib_pkg::MC_EXT_PIN_PEND])
			|| (next_st.main_ctrl[pib_pkg::MC_PIN_CHANGE_EN]
				&& next_st.main_ctrl[pib_pkg::MC_PIN_CHANGE_PEND]);
		next_st.core_irq = next_st.main_ctrl[pib_pkg::MC_GLOBAL_GATE]
			&& ((next_st.main_ctrl[pib_pkg::MC_PERIPH_GATE] && periph_any) || core_any);

		// bus-side event register: write-one-to-clear, set wins
		if (wr_acc && lane0 && address == pib_pkg::OFS_EVT_CLEAR) begin
			next_st.evt_status = st.evt_status & ~wbyte[pib_pkg::EVT_W-1:0];
		end
		if (wr_acc && lane0 && address == pib_pkg::OFS_EVT_ENABLE) begin
			next_st.evt_enable = wbyte[pib_pkg::EVT_W-1:0];
		end
		next_st.evt_status[pib_pkg::EVT_CORE_RISE] =
			next_st.evt_status[pib_pkg::EVT_CORE_RISE] | (next_st.core_irq && !st.core_irq);
		next_st.evt_status[pib_pkg::EVT_FLAG_SET] =
			next_st.evt_status[pib_pkg::EVT_FLAG_SET] | (|hw_set.req);
		next_st.evt_status[pib_pkg::EVT_BAD_ACCESS] =
			next_st.evt_status[pib_pkg::EVT_BAD_ACCESS] | bad_access;
		next_st.bus_irq = |(next_st.evt_status & next_st.evt_enable);

		if (reset) begin
			next_st = '0;
			next_st.main_ctrl = pib_pkg::RESET_BYTE;
		end
	end

	always_ff @(posedge sys_clk) begin
		st <= next_st;
	end

	assign waitrequest = (read || write) && !st.ack;
	assign readdata = {24'h000000, st.rdata};
	assign core_irq_req = st.core_irq;
	assign bus_irq = st.bus_irq;
	assign global_irq_gate = st.main_ctrl[pib_pkg::MC_GLOBAL_GATE];
	assign periph_irq_gate = st.main_ctrl[pib_pkg::MC_PERIPH_GATE];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	logic [7:0] core_srcs;
	assign core_srcs = st.main_ctrl & {3'b000, st.main_ctrl[7:3]} & 8'h07;

	a_periph_gate: assert property (
		(!st.main_ctrl[6] && core_srcs == 8'h00) |-> !core_irq_req)
		else $error("peripheral request passed a closed peripheral gate");

	a_global_gate: assert property (
		!st.main_ctrl[7] |-> !core_irq_req)
		else $error("request passed a closed global gate");

	a_flag_set: assert property (
		hw_set.req[1][7] |=> st.request[1][7] [*2])
		else $error("osc fail flag not set by its condition");

	a_unimpl_zero: assert property (
		(st.enable[1] & 8'h06) == 8'h00 && (st.request[2] & 8'hc5) == 8'h00
		&& (st.enable[3] & 8'hfc) == 8'h00 && (st.request[3] & 8'hfc) == 8'h00)
		else $error("unimplemented bit holds a one");

	// default disable would mask every attempt, so reset is watched here
	a_reset_clear: assert property (
		@(posedge sys_clk) disable iff (1'b0) reset |=> (st.enable == '0 && st.request == '0
		&& st.main_ctrl == 8'h00))
		else $error("bits not cleared by reset");

	a_rx_readonly: assert property (
		##1 st.request[0][5:4] == $past({hw_level.serial_rx_pending,
		hw_level.serial_tx_pending}))
		else $error("serial flags not following the serial unit");

	a_collision_sticky: assert property (
		(st.request[3][1] && !(write && st.ack && address == 6'h20))
		|=> st.request[3][1])
		else $error("collision flag dropped without a software write");

	a_event_hold: assert property (
		(hw_set.req[3][0] && !write) |=> st.request[3][0] ##1 st.request[3][0])
		else $error("serial two event flag lost");

	a_core_request: assert property (
		(st.main_ctrl[7] && st.main_ctrl[6] && |(st.enable & st.request))
		|-> core_irq_req)
		else $error("gated pending source raised no request");

	a_enable_two: assert property (
		(write && st.ack && byteenable[0] && address == 6'h08)
		|=> st.enable[1] == ($past(writedata[7:0]) & 8'hf9))
		else $error("enable two write misplaced");

	a_bus_answer: assert property (
		((read || write) && waitrequest) |=> !waitrequest)
		else $error("bus answer not in two cycles");

	a_enable_one: assert property (
		(write && st.ack && byteenable[0] && address == 6'h04)
		|=> st.enable[0] == $past(writedata[7:0]))
		else $error("enable one write lost");

	a_enable_three: assert property (
		(write && st.ack && byteenable[0] && address == 6'h0c)
		|=> st.enable[2] == ($past(writedata[7:0]) & 8'h3a))
		else $error("enable three write misplaced");

	a_enable_four: assert property (
		(write && st.ack && byteenable[0] && address == 6'h10)
		|=> st.enable[3] == ($past(writedata[7:0]) & 8'h03))
		else $error("enable four write misplaced");

	a_req_one_write: assert property (
		(write && st.ack && byteenable[0] && address == 6'h14)
		|=> (st.request[0] & 8'hcf) == (($past(writedata[7:0]) | $past(hw_set.req[0])) & 8'hcf))
		else $error("request one write misplaced");

	a_req_two_write: assert property (
		(write && st.ack && byteenable[0] && address == 6'h18)
		|=> st.request[1] == (($past(writedata[7:0]) | $past(hw_set.req[1])) & 8'hf9))
		else $error("request two write misplaced");

	a_req_three_write: assert property (
		(write && st.ack && byteenable[0] && address == 6'h1c)
		|=> st.request[2] == (($past(writedata[7:0]) | $past(hw_set.req[2])) & 8'h3a))
		else $error("request three write misplaced");

	a_req_four_write: assert property (
		(write && st.ack && byteenable[0] && address == 6'h20)
		|=> st.request[3] == (($past(writedata[7:0]) | $past(hw_set.req[3])) & 8'h03))
		else $error("request four write misplaced");

	a_unimpl_more: assert property (
		(st.enable[2] & 8'hc5) == 8'h00 && (st.request[1] & 8'h06) == 8'h00)
		else $error("unused bit of register two or three holds a one");

	a_read_upper_zero: assert property (
		(read && !waitrequest) |-> readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");

	a_unmapped_zero: assert property (
		(read && !waitrequest && address == 6'h30) |-> readdata == 32'h00000000)
		else $error("unmapped read not zero");

	a_req_two_hold: assert property (
		!(write && st.ack && address == 6'h18)
		|=> st.request[1] == ($past(st.request[1]) | ($past(hw_set.req[1]) & 8'hf9)))
		else $error("request two changed without cause");

	a_req_three_hold: assert property (
		!(write && st.ack && address == 6'h1c)
		|=> st.request[2] == ($past(st.request[2]) | ($past(hw_set.req[2]) & 8'h3a)))
		else $error("request three changed without cause");

	a_req_four_hold: assert property (
		!(write && st.ack && address == 6'h20)
		|=> st.request[3] == ($past(st.request[3]) | ($past(hw_set.req[3]) & 8'h03)))
		else $error("request four changed without cause");

	a_collision_set: assert property (
		hw_set.req[3][1] |=> st.request[3][1])
		else $error("collision flag not set");

	a_event_set: assert property (
		hw_set.req[3][0] |=> st.request[3][0])
		else $error("serial two event flag not set");

	a_flag_set_two: assert property (
		(hw_set.req[1] != 8'h00)
		|=> (st.request[1] & $past(hw_set.req[1]) & 8'hf9) == ($past(hw_set.req[1]) & 8'hf9))
		else $error("request two flag not set by its condition");

	a_main_write: assert property (
		(write && st.ack && byteenable[0] && address == 6'h00)
		|=> st.main_ctrl[7:3] == $past(writedata[7:3]))
		else $error("main control write lost");

	a_core_sources: assert property (
		(st.main_ctrl[7] && core_srcs != 8'h00) |-> core_irq_req)
		else $error("enabled core source raised no request");

	a_no_source: assert property (
		(core_srcs == 8'h00 && (st.enable & st.request) == '0) |-> !core_irq_req)
		else $error("request raised with nothing pending");

	a_reset_outputs: assert property (
		@(posedge sys_clk) disable iff (1'b0) reset
		|=> (!core_irq_req && !bus_irq && st.evt_status == '0 && st.evt_enable == '0))
		else $error("outputs not cleared by reset");

	// unmapped access flagged
	a_bad_access_flag: assert property (
		((read || write) && st.ack && address == 6'h30) |=> st.evt_status[2])
		else $error("unmapped access not flagged");

	// first request cycle waits
	a_wait_first: assert property (
		((read || write) && !$past(read || write)) |-> waitrequest)
		else $error("no wait cycle on a fresh request");

endmodule : pib_bank

// ---- test/pib_periph_model.sv ----
// Purpose: peripheral-side model that raises flag-set pulses and level flags
// Assumes: commands come from the bench on sys_clk
// Notes: pulses last one cycle only, as live peripherals do
`timescale 1ns/1ps
module pib_periph_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic fire,
	input wire pib_pkg::pib_set_t pattern,
	input wire pib_pkg::pib_level_t level_in,
	output pib_pkg::pib_set_t hw_set,
	output pib_pkg::pib_level_t hw_level
);
	always_ff @(posedge sys_clk) begin
		hw_set <= (fire && !reset) ? pattern : '0;
		hw_level <= reset ? '0 : level_in;
	end
endmodule : pib_periph_model

// ---- test/peripheral_interrupt_enable_flag_bank_bench.sv ----
// Purpose: self-checking bench for the interrupt enable and flag bank
// Assumes: Avalon-MM master in the bench, peripheral model on the far side
// Notes: read results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
module peripheral_interrupt_enable_flag_bank_bench;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [5:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic core_irq_req;
	logic bus_irq;
	logic global_irq_gate;
	logic periph_irq_gate;
	logic fire = 1'b0;
	pib_pkg::pib_set_t pattern = '0;
	pib_pkg::pib_level_t level_in = '0;
	pib_pkg::pib_set_t hw_set;
	pib_pkg::pib_level_t hw_level;
	logic [31:0] exp_q[$];
	int errors = 0;
	int check_count = 0;
	int seed = 32'h1659;
	int k;
	logic [7:0] r;
	logic [7:0] emask[4] = '{8'hff, 8'hf9, 8'h3a, 8'h03};

	always #50 sys_clk = ~sys_clk;

	pib_periph_model i_periph (.sys_clk(sys_clk), .reset(reset), .fire(fire),
		.pattern(pattern), .level_in(level_in), .hw_set(hw_set), .hw_level(hw_level));
	pib_bank i_dut (.sys_clk(sys_clk), .reset(reset), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .hw_set(hw_set), .hw_level(hw_level),
		.core_irq_req(core_irq_req), .bus_irq(bus_irq), .global_irq_gate(global_irq_gate),
		.periph_irq_gate(periph_irq_gate));

	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop

	// one access; held until waitrequest is seen low at a rising edge
	task automatic bus(logic [5:0] a, logic wr_n_rd, logic [7:0] d);
		@(posedge sys_clk);
		address <= a;
		writedata <= {24'h0, d};
		read <= !wr_n_rd;
		write <= wr_n_rd;
		@(posedge sys_clk);
		for (int n = 0; n < 20 && waitrequest !== 1'b0; n++) @(posedge sys_clk);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(logic [5:0] a, logic [7:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic rd(logic [5:0] a, logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(a, 1'b0, 8'h00);
	endtask : rd

	task automatic irq(logic ec, logic eb);
		repeat (2) @(posedge sys_clk);
		cmp("core_irq_req", {31'h0, ec}, {31'h0, core_irq_req});
		cmp("bus_irq", {31'h0, eb}, {31'h0, bus_irq});
	endtask : irq

	task automatic pulse(pib_pkg::pib_set_t p);
		@(posedge sys_clk);
		fire <= 1'b1;
		pattern <= p;
		@(posedge sys_clk);
		fire <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : pulse

	always @(posedge sys_clk) begin
		if (read && waitrequest === 1'b0 && exp_q.size() > 0)
			cmp("readdata", exp_q.pop_front(), readdata);
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		report_and_stop();
	end

	initial begin
		pib_pkg::pib_set_t p;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		for (k = 0; k < 9; k++) rd(6'(4 * k), 8'h00);
		wr(6'h00, 8'hc0);
		rd(6'h00, 8'hc0);
		cmp("gates", 32'h3, {30'h0, global_irq_gate, periph_irq_gate});
		for (k = 0; k < 4; k++) begin
			wr(6'(4 + 4 * k), 8'hff);
			rd(6'(4 + 4 * k), emask[k]);
			wr(6'(20 + 4 * k), 8'hff);
			rd(6'(20 + 4 * k), (k == 0) ? 8'hcf : emask[k]);
			wr(6'(20 + 4 * k), 8'h00);
			wr(6'(4 + 4 * k), 8'h00);
		end
		for (k = 0; k < 4; k++) begin
			// rx and tx are levels, kept out of the pulse pattern
			r = 8'($random(seed)) & emask[k] & 8'hcf;
			if (r == 8'h00) r = emask[k] & 8'hcf;
			p = '0;
			p.req[k] = r;
			wr(6'h00, 8'h00);
			pulse(p);
			rd(6'(20 + 4 * k), r);
			irq(1'b0, 1'b0);
			wr(6'h00, 8'h80);
			irq(1'b0, 1'b0);
			wr(6'h00, 8'hc0);
			irq(1'b0, 1'b0);
			wr(6'(4 + 4 * k), r);
			irq(1'b1, 1'b0);
			wr(6'h00, 8'h40);
			irq(1'b0, 1'b0);
			wr(6'h00, 8'hc0);
			rd(6'(20 + 4 * k), r);
			irq(1'b1, 1'b0);
			wr(6'(20 + 4 * k), 8'h00);
			rd(6'(20 + 4 * k), 8'h00);
			irq(1'b0, 1'b0);
			wr(6'(4 + 4 * k), 8'h00);
		end
		level_in.serial_rx_pending <= 1'b1;
		repeat (3) @(posedge sys_clk);
		wr(6'h14, 8'h00);
		rd(6'h14, 8'h20);
		level_in <= '0;
		wr(6'h2c, 8'h04);
		rd(6'h30, 8'h00);
		irq(1'b0, 1'b1);
		wr(6'h2c, 8'h00);
		irq(1'b0, 1'b0);
		wr(6'h2c, 8'h04);
		irq(1'b0, 1'b1);
		wr(6'h28, 8'h07);
		rd(6'h24, 8'h00);
		irq(1'b0, 1'b0);
		wr(6'h04, 8'hff);
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rd(6'h00, 8'h00);
		rd(6'h04, 8'h00);
		rd(6'h2c, 8'h00);
		report_and_stop();
	end
endmodule : peripheral_interrupt_enable_flag_bank_bench
